/* verif/bmam_asserts.sv */
// Port checker for the banked memory address map
`timescale 1ns/1ps
module bmam_asserts (
    input wire logic                 core_clk_i,
    input wire logic                 resetn_i,
    input wire bmam_pkg::bmam_preq_t preq_i,
    input wire logic [12:0]          pc_o,
    input wire logic [9:0]           pmem_addr_o,
    input wire logic [7:0]           rdata_o,
    input wire bmam_pkg::bmam_dreq_t dreq_i,
    input wire logic [7:0]           daddr_o,
    input wire logic                 sfr_sel_o,
    input wire logic                 gpr_sel_o,
    input wire logic [7:0]           status_o,
    input wire logic [7:0]           file_select_pointer_o,
    input wire logic                 bank_select_bit_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // Direct write to the status slot, either bank
    sequence s_stat_wr;
        dreq_i.wr && !dreq_i.indirect && dreq_i.addr == 7'h03;
    endsequence
    property p_stat; s_stat_wr |=> status_o == $past(dreq_i.wdata); endproperty
    a_stat: assert property (p_stat) else $error("status write lost");
    property p_irq; preq_i.irq |=> pc_o == 13'h0004; endproperty
    a_irq: assert property (p_irq) else $error("irq vector wrong");
    // Plain step must wrap at the 13-bit boundary
    property p_step; preq_i.step && !preq_i.irq && !preq_i.load |=> pc_o == $past(pc_o) + 13'h1;
    endproperty
    a_step: assert property (p_step) else $error("pc step wrong");
    property p_wrap; pmem_addr_o == pc_o[9:0]; endproperty
    a_wrap: assert property (p_wrap) else $error("fetch not wrapped");
    property p_dir; !dreq_i.indirect |-> daddr_o == {bank_select_bit_o, dreq_i.addr}; endproperty
    a_dir: assert property (p_dir) else $error("direct bank wrong");
    property p_ind; dreq_i.indirect |-> daddr_o == file_select_pointer_o; endproperty
    a_ind: assert property (p_ind) else $error("pointer address wrong");
    property p_gpr; gpr_sel_o == (daddr_o[6:0] inside {[7'h20:7'h5f]}); endproperty
    a_gpr: assert property (p_gpr) else $error("file decode wrong");
    property p_sfr; sfr_sel_o == (daddr_o[6:0] < 7'h20); endproperty
    a_sfr: assert property (p_sfr) else $error("special decode wrong");
    // Hole reads must not leak stale data
    property p_hole; dreq_i.rd && !sfr_sel_o && !gpr_sel_o |=> rdata_o == 8'h00; endproperty
    a_hole: assert property (p_hole) else $error("hole read not zero");
endmodule
bind bmam_top bmam_asserts i_bmam_asserts (.core_clk_i, .resetn_i, .preq_i, .pc_o, .pmem_addr_o,
    .rdata_o, .dreq_i, .daddr_o, .sfr_sel_o, .gpr_sel_o, .status_o, .file_select_pointer_o,
    .bank_select_bit_o);

/* verif/bmam_pmem_model.sv */
// Program memory model behind the fetch port
`timescale 1ns/1ps
module bmam_pmem_model (
    input  wire logic [9:0]  addr_i,
    output logic      [13:0] word_o
);
    // Word carries its own address, so a fetch from the wrong place shows up
    assign word_o = {4'h3, addr_i};
endmodule

/* verif/bmam_tb.sv */
// Self-checking bench for the banked memory address map
`timescale 1ns/1ps
module bmam_tb;
    logic                 core_clk_i = 1'b0;
    logic                 resetn_i   = 1'b0;
    bmam_pkg::bmam_preq_t preq_i     = '0;
    bmam_pkg::bmam_dreq_t dreq_i     = '0;
    logic [12:0]          pc_o;
    logic [9:0]           pmem_addr_o;
    logic [13:0]          pmem_rdata_i, instr_o;
    logic [7:0]           rdata_o, daddr_o, status_o, file_select_pointer_o;
    logic                 sfr_sel_o, gpr_sel_o, bank_select_bit_o;
    int                   failures = 0;
    int                   n_tests  = 0;
    // Row: op (b0 read, b1 write, b2 via pointer), address, write data, expected read
    localparam logic [31:0] ROWS [16] = '{32'h0220a500, 32'h02033800, 32'h012000a5,
        32'h025f3c00, 32'h02048500, 32'h02057700, 32'h017f0000, 32'h02031800, 32'h015f003c,
        32'h01050000, 32'h05000077, 32'h02043f00, 32'h06005a00, 32'h013f005a, 32'h02046000,
        32'h05000000};

    always #2.5 core_clk_i = ~core_clk_i;

    bmam_top i_bmam_top (.core_clk_i, .resetn_i, .preq_i, .pc_o, .pmem_addr_o, .pmem_rdata_i,
        .instr_o, .dreq_i, .rdata_o, .daddr_o, .sfr_sel_o, .gpr_sel_o, .status_o,
        .file_select_pointer_o, .bank_select_bit_o);
    bmam_pmem_model i_bmam_pmem_model (.addr_i(pmem_addr_o), .word_o(pmem_rdata_i));

    task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("tests %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Reset held four edges, then checked straight after release
    task automatic reset_dut();
        @(posedge core_clk_i);
        resetn_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        #1;
        chk(14'(pc_o), 14'h0000);
        chk(14'(status_o), 14'h0018);
    endtask

    // One fetch-side request, an idle edge, then the fetched word
    task automatic prog(input logic ld, input logic [12:0] lpc, input logic st,
                        input logic irq, input logic [12:0] exp);
        @(posedge core_clk_i);
        preq_i <= {ld, lpc, st, irq};
        @(posedge core_clk_i);
        preq_i <= '0;
        #1;
        chk(14'(pc_o), 14'(exp));
        chk(14'(pmem_addr_o), 14'(exp[9:0]));
        @(posedge core_clk_i);
        #1;
        chk(instr_o, {4'h3, exp[9:0]});
    endtask

    initial begin
        reset_dut();
        foreach (ROWS[i]) begin
            @(posedge core_clk_i);
            dreq_i <= {ROWS[i][24], ROWS[i][25], ROWS[i][26], ROWS[i][22:16], ROWS[i][15:8]};
            @(posedge core_clk_i);
            dreq_i <= '0;
            #1;
            chk(14'(rdata_o), 14'(ROWS[i][7:0]));
        end
        prog(1'b1, 13'h0404, 1'b0, 1'b0, 13'h0404);
        prog(1'b1, 13'h1fff, 1'b0, 1'b0, 13'h1fff);
        prog(1'b0, 13'h0000, 1'b1, 1'b0, 13'h0000);
        // Interrupt wins over a load and a step in the same cycle
        prog(1'b1, 13'h0100, 1'b1, 1'b1, 13'h0004);
        prog(1'b0, 13'h0000, 1'b1, 1'b0, 13'h0005);
        // Bank 1 left selected, so the mid-run reset must bring status back
        @(posedge core_clk_i);
        dreq_i <= {3'h2, 7'h03, 8'h38};
        @(posedge core_clk_i);
        dreq_i <= {3'h4, 7'h5f, 8'h00};
        #1;
        chk(14'(status_o), 14'h0038);
        chk(14'(bank_select_bit_o), 14'h0001);
        chk(14'(daddr_o), 14'h00df);
        chk(14'({sfr_sel_o, gpr_sel_o}), 14'h0001);
        @(posedge core_clk_i);
        dreq_i <= '0;
        #1;
        chk(14'(rdata_o), 14'h003c);
        reset_dut();
        end_sim();
    end

    // Run needs well under a microsecond; this only cuts a hang short
    initial begin
        #5000;
        failures++;
        end_sim();
    end
endmodule

/* verilog/bmam_gpr_mem.sv */
// 64 x 8 general purpose file with registered read data
`timescale 1ns/1ps
module bmam_gpr_mem (
    input  wire logic       core_clk_i,
    input  wire logic       we_i,
    input  wire logic [5:0] waddr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic [5:0] raddr_i,
    output logic      [7:0] rdata_o
);
    logic [7:0] mem [0:63];

    // No reset on the array: contents are undefined at power-up like real SRAM
    always_ff @(posedge core_clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule

/* verilog/bmam_pkg.sv */
// Package of constants and carrier types for the banked memory address map
package bmam_pkg;

    // Program side
    localparam int          PC_W          = 13;
    localparam int          PWORD_W       = 14;
    localparam int          PMEM_AW       = 10;
    localparam logic [12:0] RESET_VECTOR  = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR    = 13'h0004;

    // Data side
    localparam int          DADDR_W       = 8;
    localparam int          DATA_W        = 8;
    localparam int          GPR_AW        = 6;
    localparam int          GPR_DEPTH     = 64;
    localparam int          SFR_COUNT     = 32;
    localparam logic [6:0]  SFR_LAST      = 7'h1f;
    localparam logic [6:0]  GPR_FIRST     = 7'h20;
    localparam logic [6:0]  GPR_LAST      = 7'h5f;

    // Status register layout and reset value
    localparam logic [4:0]  STATUS_ADDR   = 5'h03;
    localparam logic [4:0]  FSR_ADDR      = 5'h04;
    localparam int          STATUS_BANK_BIT = 5;
    localparam logic [7:0]  STATUS_RESET  = 8'h18;
    localparam logic [7:0]  STATUS_RSVD_MASK = 8'hc0;
    localparam logic [7:0]  SFR_RESET     = 8'h00;
    localparam logic [13:0] INSTR_RESET   = 14'h0000;

    // Decoded target of a data access
    typedef enum logic [1:0] {
        BMAM_TGT_SFR  = 2'b00,
        BMAM_TGT_GPR  = 2'b01,
        BMAM_TGT_NONE = 2'b11
    } bmam_target_t;

    // Data access request from the core
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       indirect;
        logic [6:0] addr;
        logic [7:0] wdata;
    } bmam_dreq_t;

    // Program fetch request from the core
    typedef struct packed {
        logic       load;
        logic [12:0] load_pc;
        logic       step;
        logic       irq;
    } bmam_preq_t;

endpackage

/* verilog/bmam_top.sv */
// Banked memory address map: program fetch addressing and data file decode
// Behaviour
// - Program counter is 13 bits, 8K x 14 space
// - Only addresses 000h-3FFh have physical storage
// - Fetches above 1K wrap into first 1K
// - Reset starts at 0000h, interrupt loads 0004h
// - Two banks, lowest 32 addresses are SFRs
// - 20h-5Fh is RAM shared by both banks
// - Unimplemented data addresses read as zero
// - Status bit 5 selects bank for direct access
// - 64-byte file, direct and pointer access
// - SFRs are static, hold contents without refresh
`timescale 1ns/1ps
module bmam_top (
    input  wire logic                  core_clk_i,
    input  wire logic                  resetn_i,
    // Program side
    input  wire bmam_pkg::bmam_preq_t  preq_i,
    output logic               [12:0]  pc_o,
    output logic                [9:0]  pmem_addr_o,
    input  wire logic          [13:0]  pmem_rdata_i,
    output logic               [13:0]  instr_o,
    // Data side
    input  wire bmam_pkg::bmam_dreq_t  dreq_i,
    output logic                [7:0]  rdata_o,
    output logic                [7:0]  daddr_o,
    output logic                       sfr_sel_o,
    output logic                       gpr_sel_o,
    output logic                [7:0]  status_o,
    output logic                [7:0]  file_select_pointer_o,
    output logic                       bank_select_bit_o
);

    // Decode a full data address into its target
    function automatic bmam_pkg::bmam_target_t decode_target(input logic [7:0] a);
        if (a[6:0] <= bmam_pkg::SFR_LAST) begin
            decode_target = bmam_pkg::BMAM_TGT_SFR;
        end else if (a[6:0] >= bmam_pkg::GPR_FIRST && a[6:0] <= bmam_pkg::GPR_LAST) begin
            decode_target = bmam_pkg::BMAM_TGT_GPR;
        end else begin
            decode_target = bmam_pkg::BMAM_TGT_NONE;
        end
    endfunction

    // Map a data address onto an SFR slot: bank 1 takes slots 32..63
    function automatic logic [5:0] sfr_slot(input logic [7:0] a);
        sfr_slot = {a[7], a[4:0]};
    endfunction

    // Status and pointer are the offsets that answer alike from either bank
    function automatic logic is_shared_slot(input logic [4:0] ofs);
        is_shared_slot = (ofs == bmam_pkg::STATUS_ADDR) || (ofs == bmam_pkg::FSR_ADDR);
    endfunction

    // ---------------- Program counter ----------------
    logic [12:0] pc;
    logic [12:0] next_pc;
    logic [13:0] instr;
    logic [13:0] next_instr;

    // Interrupt outranks a load, which outranks a step
    // The full 13-bit count is kept even past 03FFh, so a saved return address
    // and a later computed jump stay exact; only the fetch address folds
    always_comb begin
        next_pc    = pc;
        next_instr = pmem_rdata_i;
        if (preq_i.irq) begin
            next_pc = bmam_pkg::IRQ_VECTOR;
        end else if (preq_i.load) begin
            next_pc = preq_i.load_pc;
        end else if (preq_i.step) begin
            next_pc = pc + 13'h0001;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pc    <= bmam_pkg::RESET_VECTOR;
            // A cleared word keeps the core from decoding a stale fetch
            instr <= bmam_pkg::INSTR_RESET;
        end else begin
            pc    <= next_pc;
            instr <= next_instr;
        end
    end

    // Upper PC bits are dropped so any fetch wraps into the implemented 1K
    // (a fetch at 0400h returns the same word as one at 0000h)
    assign pmem_addr_o = pc[9:0];
    assign pc_o        = pc;
    assign instr_o     = instr;

    // ---------------- Data side decode ----------------
    logic [7:0]   status;
    logic [7:0]   file_select_pointer;
    logic [7:0]   daddr;
    bmam_pkg::bmam_target_t tgt;

    // Direct access takes the bank bit; indirect takes the whole pointer
    // Pointer bit 7 picks the bank itself, so the bank bit plays no part there
    always_comb begin
        if (dreq_i.indirect) begin
            daddr = file_select_pointer;
        end else begin
            daddr = {status[bmam_pkg::STATUS_BANK_BIT], dreq_i.addr};
        end
        tgt = decode_target(daddr);
    end

    // One decode feeds the select outputs and both write enables
    logic         hit_sfr;
    logic         hit_gpr;

    assign hit_sfr   = (tgt == bmam_pkg::BMAM_TGT_SFR);
    assign hit_gpr   = (tgt == bmam_pkg::BMAM_TGT_GPR);
    assign daddr_o   = daddr;
    assign sfr_sel_o = hit_sfr;
    assign gpr_sel_o = hit_gpr;

    // ---------------- Special function registers ----------------
    // 2 x 32 slots; status and pointer sit at the same offsets in both banks
    logic [7:0] sfr      [0:63];
    logic [7:0] next_sfr [0:63];
    logic       sfr_wr;
    logic [5:0] slot;

    assign sfr_wr = dreq_i.wr && hit_sfr;
    assign slot   = sfr_slot(daddr);

    genvar g;
    generate
        for (g = 0; g < 64; g++) begin : g_sfr
            localparam logic [4:0] OFS    = 5'(g);
            localparam bit         SHARED = is_shared_slot(OFS);
            // Shared slots answer from either bank; others only in their own bank
            always_comb begin
                next_sfr[g] = sfr[g];
                if (sfr_wr && ((SHARED && slot[4:0] == OFS) || (!SHARED && slot == 6'(g)))) begin
                    next_sfr[g] = dreq_i.wdata;
                end
            end
            // Static storage: plain flops, no refresh needed
            always_ff @(posedge core_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    sfr[g] <= (OFS == bmam_pkg::STATUS_ADDR) ? bmam_pkg::STATUS_RESET
                                                             : bmam_pkg::SFR_RESET;
                end else begin
                    sfr[g] <= next_sfr[g];
                end
            end
        end
    endgenerate

    // Bank 0 copies of the shared registers are the live ones
    // A bank 1 write lands in both copies, so the bank 0 copy is always current
    assign status = sfr[bmam_pkg::STATUS_ADDR];
    assign file_select_pointer    = sfr[bmam_pkg::FSR_ADDR];
    assign status_o              = status;
    assign file_select_pointer_o = file_select_pointer;
    assign bank_select_bit_o     = status[bmam_pkg::STATUS_BANK_BIT];

    // ---------------- General purpose file ----------------
    logic [7:0] gpr_rdata;
    logic [5:0] gpr_index;

    // Same physical byte whatever the bank: subtract base, ignore bank bit
    assign gpr_index = 6'(daddr[6:0] - bmam_pkg::GPR_FIRST);

    logic       gpr_we;

    // Only decoded file addresses write; holes and SFRs leave the RAM alone
    assign gpr_we = dreq_i.wr && hit_gpr;

    // One index serves read and write: a byte written now reads back next cycle
    bmam_gpr_mem u_gpr (
        .core_clk_i (core_clk_i),
        .we_i       (gpr_we),
        .waddr_i    (gpr_index),
        .wdata_i    (dreq_i.wdata),
        .raddr_i    (gpr_index),
        .rdata_o    (gpr_rdata)
    );

    // ---------------- Read data ----------------
    // Read data lands one cycle after the request to match the RAM latency
    bmam_pkg::bmam_target_t rd_tgt;
    bmam_pkg::bmam_target_t next_rd_tgt;
    logic [7:0] sfr_q;
    logic [7:0] next_sfr_q;

    always_comb begin
        next_rd_tgt = dreq_i.rd ? tgt : bmam_pkg::BMAM_TGT_NONE;
        next_sfr_q  = sfr[slot];
        // Shared offsets read their bank 0 copy whichever bank asked
        if (is_shared_slot(slot[4:0])) begin
            next_sfr_q = sfr[{1'h0, slot[4:0]}];
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_tgt <= bmam_pkg::BMAM_TGT_NONE;
            sfr_q  <= bmam_pkg::SFR_RESET;
        end else begin
            rd_tgt <= next_rd_tgt;
            sfr_q  <= next_sfr_q;
        end
    end

    // Both sources are already registered, so this mux adds no cycle; a cycle
    // with no read, or a read of a hole, gives zero rather than stale data
    always_comb begin
        case (rd_tgt)
            bmam_pkg::BMAM_TGT_SFR:  rdata_o = sfr_q;
            bmam_pkg::BMAM_TGT_GPR:  rdata_o = gpr_rdata;
            default:                 rdata_o = 8'h00;
        endcase
    end

    // Reserved status bits 7:6 are stored as written; software keeps them zero
    // so no masking is applied here. A stray one would show only on status_o and in reads of status:
    // the pointer page and upper bank are not decoded, so addressing is unchanged.
endmodule
